// File: hdl/icxd_pkg.sv
// package: constants and types shared by the expander and its bus master
// assumes a single 100 MHz mclk domain at each end
// Function
// - address pins enable pull-ups per four-input group
// - bus-tied pin high selects, low deselects pull-ups
// - slave address 110, high pin bits, low pin bits
// - bus-tied pins decoded from first bus transfer
// - integrator prefers supply or ground address straps
// - inputs compared with snapshot, differences set flags
// - snapshot loaded and flags cleared at acknowledge
// - two-byte read: inputs, then pre-clear flags
// - long reads alternate bytes, resampling each pair
// - eight-bit mask selects alerting inputs
// - flags set regardless of mask
// - no alert during read, deferred to stop
// - no alert at stop if change already returned
// - flags stay set until next access
// - device is slave only; master drives clock
// - master frames start, address, data, stop
// - start and stop are data edges, clock high
// - data stable while clock high
// - reset: mask all ones, flags clear, alert released
// - abort voids transfer, keeps alert and mask
// - alert low on masked change, released on access
package icxd_pkg;
	localparam int           ICXD_WIDTH    = 8;
	localparam logic [2:0]   ICXD_ADDR_TOP = 3'h6;
	// four-level pin encodings for the address pins
	typedef enum logic [1:0] {ICXD_PIN_GND, ICXD_PIN_VDD, ICXD_PIN_SCL,
		ICXD_PIN_SDA} icxd_pin_t;
	localparam logic [1:0]   ICXD_HI_SCL   = 2'h0;
	localparam logic [1:0]   ICXD_HI_SDA   = 2'h1;
	localparam logic [1:0]   ICXD_HI_GND   = 2'h2;
	localparam logic [1:0]   ICXD_HI_VDD   = 2'h3;
	localparam logic [1:0]   ICXD_LO_GND   = 2'h0;
	localparam logic [1:0]   ICXD_LO_VDD   = 2'h1;
	localparam logic [1:0]   ICXD_LO_SCL   = 2'h2;
	localparam logic [1:0]   ICXD_LO_SDA   = 2'h3;
	localparam logic [7:0]   ICXD_MASK_RST = 8'hFF;
	localparam logic [3:0]   ICXD_LAST_BIT = 4'h7;
	localparam logic [3:0]   ICXD_ACK_BIT  = 4'h8;
	// master: link clock half period in mclk cycles (100 MHz, 160 ns period)
	localparam int           ICXD_CLK_MHZ  = 100;
	localparam int           ICXD_SCL_NS   = 160;
	localparam int           ICXD_HALF_CYC = ICXD_SCL_NS * ICXD_CLK_MHZ
		/ 2000;
	// master register offsets on AXI4-Lite
	localparam logic [3:0]   ICXD_REG_CTRL = 4'h0;
	localparam logic [3:0]   ICXD_REG_STAT = 4'h4;
	localparam logic [3:0]   ICXD_REG_DATA = 4'h8;
	localparam logic [1:0]   ICXD_RESP_OK  = 2'h0;
	localparam logic [1:0]   ICXD_RESP_ERR = 2'h2;
	// pin level helper: high address bits from pin class
	function automatic logic [1:0] icxdHiBits(input icxd_pin_t p);
		case (p)
			ICXD_PIN_SCL: icxdHiBits = ICXD_HI_SCL;
			ICXD_PIN_SDA: icxdHiBits = ICXD_HI_SDA;
			ICXD_PIN_GND: icxdHiBits = ICXD_HI_GND;
			default:      icxdHiBits = ICXD_HI_VDD;
		endcase
	endfunction
	function automatic logic [1:0] icxdLoBits(input icxd_pin_t p);
		case (p)
			ICXD_PIN_GND: icxdLoBits = ICXD_LO_GND;
			ICXD_PIN_VDD: icxdLoBits = ICXD_LO_VDD;
			ICXD_PIN_SCL: icxdLoBits = ICXD_LO_SCL;
			default:      icxdLoBits = ICXD_LO_SDA;
		endcase
	endfunction
endpackage

// File: hdl/icxd_link_if.sv
// interface: open-drain two-wire link between master and expander
// assumes external pull-ups; each party drives low only through oe
`timescale 1ns/10ps
interface icxd_link_if;
	logic sclOe;
	logic sdaOeM;
	logic sdaOeS;
	logic scl;
	logic sda;
	assign scl = ~sclOe;
	assign sda = ~(sdaOeM | sdaOeS);
	modport master (output sclOe, output sdaOeM, input scl, input sda);
	modport slave  (output sdaOeS, input scl, input sda);
endinterface

// File: hdl/icxd_expander.sv
// expander end: sense inputs, snapshot, change flags, mask, alert
// assumes mclk much faster than the link clock; pins are asynchronous
`timescale 1ns/10ps
module icxd_expander
	import icxd_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	icxd_link_if.slave                 link,
	input  wire logic                  abort_b,
	input  wire logic [ICXD_WIDTH-1:0] sense_inputs,
	input  wire logic [1:0]            addr_pin_high_pair,
	input  wire logic [1:0]            addr_pin_low_pair,
	output logic                       alertOe,
	output logic [ICXD_WIDTH-1:0]      pullupEn
);
	typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, TX, TX_ACK, RX,
		RX_ACK, IGNORE} icxd_st_t;

	// ********************************************************
	// synchronisers
	// ********************************************************
	logic [1:0]            sclS_q, sdaS_q, abS_q;
	logic [1:0]            hiS1_q, hiS2_q, loS1_q, loS2_q;
	logic [ICXD_WIDTH-1:0] inS1_q, inS2_q;
	logic                  sclD_q, sdaD_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sclS_q <= 2'h3;
			sdaS_q <= 2'h3;
			abS_q  <= 2'h3;
			hiS1_q <= '1;
			hiS2_q <= '1;
			loS1_q <= '1;
			loS2_q <= '1;
			inS1_q <= '0;
			inS2_q <= '0;
			sclD_q <= 1'b1;
			sdaD_q <= 1'b1;
		end else begin
			sclS_q <= {sclS_q[0], link.scl};
			sdaS_q <= {sdaS_q[0], link.sda};
			abS_q  <= {abS_q[0], abort_b};
			hiS1_q <= addr_pin_high_pair;
			hiS2_q <= hiS1_q;
			loS1_q <= addr_pin_low_pair;
			loS2_q <= loS1_q;
			inS1_q <= sense_inputs;
			inS2_q <= inS1_q;
			sclD_q <= sclS_q[1];
			sdaD_q <= sdaS_q[1];
		end
	end
	logic scl, sda, sclRise, sclFall, startEv, stopEv, abortNow;
	assign scl      = sclS_q[1];
	assign sda      = sdaS_q[1];
	assign sclRise  = scl & ~sclD_q;
	assign sclFall  = ~scl & sclD_q;
	assign startEv  = scl & sclD_q & sdaD_q & ~sda;
	assign stopEv   = scl & sclD_q & ~sdaD_q & sda;
	assign abortNow = ~abS_q[1];

	// ********************************************************
	// address pins and pull-ups
	// ********************************************************
	// pin class: static level until first start, then bus-tied read
	logic     seenBus_q;
	icxd_pin_t hiCls_q, loCls_q;
	function automatic icxd_pin_t classify(input logic [1:0] p,
		input logic seen);
		// p[1]=1 tied to bus line, p[0]=0 scl / 1 sda; else static level
		if (p[1] && seen)
			classify = p[0] ? ICXD_PIN_SDA : ICXD_PIN_SCL;
		else if (p[1])
			classify = ICXD_PIN_VDD;
		else
			classify = p[0] ? ICXD_PIN_VDD : ICXD_PIN_GND;
	endfunction
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			seenBus_q <= 1'b0;
			hiCls_q   <= ICXD_PIN_VDD;
			loCls_q   <= ICXD_PIN_VDD;
		end else begin
			if (startEv)
				seenBus_q <= 1'b1;
			hiCls_q <= classify(hiS2_q, seenBus_q);
			loCls_q <= classify(loS2_q, seenBus_q);
		end
	end
	// bus-tied pin follows its line level; ground disables
	function automatic logic pullSel(input icxd_pin_t c, input logic sv,
		input logic dv);
		case (c)
			ICXD_PIN_GND: pullSel = 1'b0;
			ICXD_PIN_SCL: pullSel = sv;
			ICXD_PIN_SDA: pullSel = dv;
			default:      pullSel = 1'b1;
		endcase
	endfunction
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			pullupEn <= '1;
		else
			pullupEn <= {{4{pullSel(hiCls_q, scl, sda)}},
				{4{pullSel(loCls_q, scl, sda)}}};
	end
	logic [6:0] myAddr;
	assign myAddr = {ICXD_ADDR_TOP, icxdHiBits(hiCls_q),
		icxdLoBits(loCls_q)};

	// ********************************************************
	// serial engine
	// ********************************************************
	icxd_st_t              st_q;
	logic [3:0]            bit_q;
	logic [7:0]            sh_q;
	logic                  isRead_q, pairOdd_q, sdaOe_q, readSeen_q;
	logic [ICXD_WIDTH-1:0] snap_q, flags_q, flagsOld_q, mask_q;
	logic                  sampleNow;
	// snapshot at address and write-byte acknowledges; a long read resamples only where
	// the master acks a flags byte, so the pre-clear flags still go out
	assign sampleNow = sclRise && ((st_q == ADDR_ACK) ||
		(st_q == TX_ACK && pairOdd_q && !sda) || st_q == RX_ACK);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= IDLE;
			bit_q <= '0;
			sh_q <= '0;
			isRead_q <= 1'b0;
			pairOdd_q <= 1'b0;
			sdaOe_q <= 1'b0;
		end else if (abortNow || stopEv) begin
			st_q <= IDLE;
			sdaOe_q <= 1'b0;
			isRead_q <= 1'b0;
		end else if (startEv) begin
			st_q <= ADDR;
			bit_q <= '0;
			isRead_q <= 1'b0;
		end else if (sclRise && (st_q == ADDR || st_q == RX)) begin
			sh_q <= {sh_q[6:0], sda};
			bit_q <= bit_q + 4'h1;
		end else if (sclFall) begin
			case (st_q)
				ADDR: if (bit_q == ICXD_ACK_BIT) begin
					if (sh_q[7:1] == myAddr) begin
						st_q <= ADDR_ACK;
						isRead_q <= sh_q[0];
						sdaOe_q <= 1'b1;
					end else
						st_q <= IGNORE;
				end
				ADDR_ACK, RX_ACK: begin
					bit_q <= '0;
					pairOdd_q <= 1'b0;
					st_q <= isRead_q ? TX : RX;
					sdaOe_q <= isRead_q ? ~inS2_q[ICXD_WIDTH-1] : 1'b0;
					sh_q <= {inS2_q[ICXD_WIDTH-2:0], 1'b0};
				end
				RX: if (bit_q == ICXD_ACK_BIT) begin
					st_q <= RX_ACK;
					sdaOe_q <= 1'b1;
				end
				TX: if (bit_q == ICXD_LAST_BIT) begin
					st_q <= TX_ACK;
					sdaOe_q <= 1'b0;
				end else begin
					bit_q <= bit_q + 4'h1;
					sdaOe_q <= ~sh_q[7];
					sh_q <= {sh_q[6:0], 1'b0};
				end
				TX_ACK: begin
					// alternate inputs and pre-clear flags
					bit_q <= '0;
					pairOdd_q <= ~pairOdd_q;
					st_q <= TX;
					if (pairOdd_q) begin
						sdaOe_q <= ~inS2_q[ICXD_WIDTH-1];
						sh_q <= {inS2_q[ICXD_WIDTH-2:0], 1'b0};
					end else begin
						sdaOe_q <= ~flagsOld_q[ICXD_WIDTH-1];
						sh_q <= {flagsOld_q[ICXD_WIDTH-2:0], 1'b0};
					end
				end
				default: ;
			endcase
		end else if (sclRise && st_q == TX_ACK && sda)
			st_q <= IGNORE;                     // master nack ends reads
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			link.sdaOeS <= 1'b0;
		else
			link.sdaOeS <= sdaOe_q;
	end

	// ********************************************************
	// snapshot, change flags, mask
	// ********************************************************
	// snapshot follows the inputs until the synchronisers have filled,
	// otherwise reset itself would look like a change on every input that reads high
	logic [2:0] settle_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			settle_q <= '0;
		else
			settle_q <= {settle_q[1:0], 1'b1};
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			snap_q <= '0;
			flags_q <= '0;
			flagsOld_q <= '0;
		end else if (!settle_q[2]) begin
			snap_q <= inS2_q;
		end else if (sampleNow) begin
			snap_q <= inS2_q;
			flagsOld_q <= flags_q | (snap_q ^ inS2_q);
			flags_q <= '0;
		end else
			flags_q <= flags_q | (snap_q ^ inS2_q);
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			mask_q <= ICXD_MASK_RST;
		else if (sclFall && st_q == RX && bit_q == ICXD_ACK_BIT)
			mask_q <= sh_q;
	end

	// ********************************************************
	// alert
	// ********************************************************
	logic alertReq, inRead;
	assign alertReq = |(flags_q & mask_q);
	// held through the master's nack until stop, not only while sending
	assign inRead   = isRead_q && st_q != IDLE;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			readSeen_q <= 1'b0;
		else
			readSeen_q <= inRead;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			alertOe <= 1'b0;
		else if (sampleNow)
			alertOe <= 1'b0;
		else if (!inRead && !readSeen_q && alertReq)
			alertOe <= 1'b1;
		else if (readSeen_q && !inRead && alertReq)
			alertOe <= 1'b1;
	end
endmodule

// File: hdl/icxd_master.sv
// master end: AXI4-Lite slave registers driving a two-wire byte engine
// assumes the expander end joined through icxd_link_if
`timescale 1ns/10ps
module icxd_master
	import icxd_pkg::*;
#(
	parameter int HALF = ICXD_HALF_CYC
)(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	icxd_link_if.master      link,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	// ctrl: [0] go, [1] start, [2] stop, [3] read, [4] nack, [15:8] byte
	typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP}
		icxd_mst_t;
	icxd_mst_t   mst_q;
	logic [7:0]  txB_q, rxB_q;
	logic [3:0]  bitN_q;
	logic [15:0] cnt_q;
	logic [1:0]  ph_q;
	logic        busy_q, ackIn_q, doStop_q, rd_q, nack_q, wrA_q, wrD_q;
	logic [3:0]  wa_q;
	logic [31:0] wd_q;
	logic [1:0]  sclS_q, sdaS_q;
	logic        tick, go;

	// ********************************************************
	// AXI4-Lite slave
	// ********************************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			awready <= 1'b1; wready <= 1'b1; bvalid <= 1'b0;
			bresp <= ICXD_RESP_OK; wrA_q <= 1'b0; wrD_q <= 1'b0;
			wa_q <= '0; wd_q <= '0;
		end else begin
			if (awvalid && awready) begin
				wa_q <= awaddr; wrA_q <= 1'b1; awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wd_q <= wdata; wrD_q <= 1'b1; wready <= 1'b0;
			end
			if (wrA_q && wrD_q && !bvalid) begin
				bvalid <= 1'b1;
				bresp <= (wa_q == ICXD_REG_CTRL) ? ICXD_RESP_OK
					: ICXD_RESP_ERR;
				wrA_q <= 1'b0; wrD_q <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0; awready <= 1'b1; wready <= 1'b1;
			end
		end
	end
	assign go = wrA_q && wrD_q && !bvalid && wa_q == ICXD_REG_CTRL
		&& wd_q[0] && !busy_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b1; rvalid <= 1'b0; rdata <= '0;
			rresp <= ICXD_RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0; rvalid <= 1'b1; rresp <= ICXD_RESP_OK;
			if (araddr == ICXD_REG_STAT)
				rdata <= {30'h0000_0000, ackIn_q, busy_q};
			else if (araddr == ICXD_REG_DATA)
				rdata <= {24'h00_0000, rxB_q};
			else begin
				rdata <= '0; rresp <= ICXD_RESP_ERR;
			end
		end else if (rvalid && rready) begin
			rvalid <= 1'b0; arready <= 1'b1;
		end
	end

	// ********************************************************
	// bit engine: four phases per bit, clock made by divider
	// ********************************************************
	assign tick = (cnt_q == 16'(HALF / 2 - 1));
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sclS_q <= 2'h3; sdaS_q <= 2'h3;
		end else begin
			sclS_q <= {sclS_q[0], link.scl};
			sdaS_q <= {sdaS_q[0], link.sda};
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mst_q <= M_IDLE; busy_q <= 1'b0; cnt_q <= '0; ph_q <= '0;
			bitN_q <= '0; txB_q <= '0; rxB_q <= '0; ackIn_q <= 1'b0;
			doStop_q <= 1'b0; rd_q <= 1'b0; nack_q <= 1'b0;
			link.sclOe <= 1'b0; link.sdaOeM <= 1'b0;
		end else if (go) begin
			busy_q <= 1'b1; txB_q <= wd_q[15:8]; rd_q <= wd_q[3];
			nack_q <= wd_q[4]; doStop_q <= wd_q[2];
			bitN_q <= '0; ph_q <= '0; cnt_q <= '0;
			mst_q <= wd_q[1] ? M_START : M_BIT;
		end else if (busy_q) begin
			cnt_q <= tick ? '0 : cnt_q + 16'h0001;
			if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (mst_q)
					M_START: case (ph_q)
						2'h0: begin link.sdaOeM <= 1'b0; link.sclOe <= 1'b0; end
						2'h1: link.sdaOeM <= 1'b1;
						2'h2: link.sclOe <= 1'b1;
						default: begin mst_q <= M_BIT; ph_q <= '0; end
					endcase
					M_BIT, M_ACK: case (ph_q)
						2'h0: link.sdaOeM <= (mst_q == M_ACK)
							? (rd_q && !nack_q) : (!rd_q && !txB_q[7]);
						2'h1: link.sclOe <= 1'b0;
						2'h2: if (mst_q == M_ACK) ackIn_q <= ~sdaS_q[1];
							else rxB_q <= {rxB_q[6:0], sdaS_q[1]};
						default: begin
							link.sclOe <= 1'b1;
							txB_q <= {txB_q[6:0], 1'b0};
							if (mst_q == M_ACK)
								mst_q <= doStop_q ? M_STOP : M_IDLE;
							else if (bitN_q == ICXD_LAST_BIT)
								mst_q <= M_ACK;
							bitN_q <= bitN_q + 4'h1;
							if (mst_q == M_ACK && !doStop_q) busy_q <= 1'b0;
						end
					endcase
					M_STOP: case (ph_q)
						2'h0: link.sdaOeM <= 1'b1;
						2'h1: link.sclOe <= 1'b0;
						2'h2: link.sdaOeM <= 1'b0;
						default: begin mst_q <= M_IDLE; busy_q <= 1'b0; end
					endcase
					default: busy_q <= 1'b0;
				endcase
			end
		end
	end
endmodule

// File: testbench/icxd_chk.sv
// checker: relations on the link wires and the expander's own pins
// assumes one mclk domain and a master at its default link rate
`timescale 1ns/10ps
module icxd_chk
	import icxd_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       abort_b,
	input wire logic       sdaOeS,
	input wire logic       scl,
	input wire logic       sda,
	input wire logic [1:0] addr_pin_high_pair,
	input wire logic [1:0] addr_pin_low_pair,
	input wire logic       alertOe,
	input wire logic [7:0] pullupEn
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ********************************
	// link and alert relations
	// ********************************
	slave_edge_a: assert property (disable iff (!rst_b || !abort_b)
		$changed(sdaOeS) |-> !scl) else $error("slave moved data, clock high");
	bit_hold_a: assert property (disable iff (!rst_b || !abort_b)
		$rose(sdaOeS) |-> sdaOeS[*4]) else $error("slave bit too short");
	idle_lines_a: assert property (
		$rose(rst_b) |-> scl && sda && !alertOe) else $error("not idle");
	start_clock_a: assert property (
		$fell(sda) && scl |-> ##[1:40] !scl) else $error("start not clocked");
	// static straps only: bus-tied pins depend on when they were decoded
	hi_pull_a: assert property (
		$rose(sda) && scl && !addr_pin_high_pair[1] |-> ##[1:20]
		pullupEn[7:4] == {4{addr_pin_high_pair[0]}}) else $error("high pull");
	lo_pull_a: assert property (
		$rose(sda) && scl && !addr_pin_low_pair[1] |-> ##[1:20]
		pullupEn[3:0] == {4{addr_pin_low_pair[0]}}) else $error("low pull");
	alert_clear_a: assert property (
		$fell(alertOe) |-> $past(sdaOeS)) else $error("alert left off ack");
	abort_rel_a: assert property (
		$fell(abort_b) |-> ##[1:6] !sdaOeS) else $error("abort kept data");
endmodule

// File: testbench/icxd_bench.sv
// bench: master and expander joined by the link, driven over AXI4-Lite
// assumes the design package and interface are compiled first
`timescale 1ns/10ps
`define CHK(a, e) begin \
	cmp_count++; \
	if ((a) !== (e)) begin \
		miscompares++; \
		$display("mismatch at %0t: got %h want %h", $time, (a), (e)); \
	end \
end
module icxd_bench
	import icxd_pkg::*;
;
	logic        mclk, rst_b, abort_b, alertOe;
	logic [7:0]  sense, pullupEn, rx, rx2, old;
	logic [1:0]  hiPin, loPin, r;
	logic [3:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, ack;
	logic [6:0]  adr;
	integer      seed, miscompares, cmp_count, cycles;
	icxd_link_if link();
	icxd_expander icxd_expander_i(.mclk(mclk), .rst_b(rst_b), .link(link),
		.abort_b(abort_b), .sense_inputs(sense),
		.addr_pin_high_pair(hiPin), .addr_pin_low_pair(loPin),
		.alertOe(alertOe), .pullupEn(pullupEn));
	icxd_master #(.HALF(ICXD_HALF_CYC)) icxd_master_i(.mclk(mclk),
		.rst_b(rst_b),
		.link(link), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	icxd_chk icxd_chk_i(.mclk(mclk), .rst_b(rst_b), .abort_b(abort_b),
		.sdaOeS(link.sdaOeS), .scl(link.scl), .sda(link.sda),
		.addr_pin_high_pair(hiPin), .addr_pin_low_pair(loPin),
		.alertOe(alertOe), .pullupEn(pullupEn));
	// ********************************
	// clock, timeout, verdict
	// ********************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic tally_and_finish;
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 80000) begin
			miscompares++;
			$display("mismatch at %0t: run hung", $time);
			tally_and_finish;
		end
	end
	// ********************************
	// bus tasks
	// ********************************
	task automatic axiWr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axiRd(input logic [3:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// one byte on the link; busy is polled, never timed
	task automatic xfer(input logic [15:0] ctl);
		axiWr(ICXD_REG_CTRL, {16'h0000, ctl});
		do axiRd(ICXD_REG_STAT); while (d[0] === 1'b1);
		ack = d[1];
		axiRd(ICXD_REG_DATA);
		rx = d[7:0];
	endtask
	task automatic wrB(input logic st, input logic sp, input logic [7:0] b);
		xfer({b, 5'h00, sp, st, 1'b1});
	endtask
	// the last byte of a read is refused by the master
	task automatic rdB(input logic sp);
		xfer({8'hFF, 3'h0, sp, 1'b1, sp, 2'h1});
	endtask
	task automatic flip(input logic [7:0] m);
		@(posedge mclk);
		sense <= sense ^ m;
		repeat (20) @(posedge mclk);
	endtask
	function automatic logic [6:0] expAddr(input logic [1:0] h,
		input logic [1:0] l);
		expAddr = {3'h6, h ^ 2'h2, l};
	endfunction
	// ********************************
	// scenarios
	// ********************************
	initial begin
		seed = 32'he860_9fd1;
		miscompares = 0;
		cmp_count = 0;
		cycles = 0;
		{rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		abort_b = 1'b1;
		sense = $random(seed);
		// supply straps: right even before the first transfer
		hiPin = 2'h1;
		loPin = 2'h1;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		`CHK(alertOe, 1'b0)
		axiWr(4'hC, 32'h0000_0001);
		`CHK(r, ICXD_RESP_ERR)
		axiRd(4'hC);
		`CHK(r, ICXD_RESP_ERR)
		`CHK(d, 32'h0000_0000)
		for (int i = 0; i < 16; i++) begin
			hiPin <= i[3:2];
			loPin <= i[1:0];
			adr = expAddr(i[3:2], i[1:0]);
			wrB(1'b1, 1'b0, {adr, 1'b0});
			`CHK(ack, 1'b1)
			wrB(1'b0, 1'b1, 8'hFF);
			`CHK(ack, 1'b1)
			`CHK(pullupEn, {{4{i[3:2] != 2'h0}}, {4{i[1:0] != 2'h0}}})
			wrB(1'b1, 1'b1, {adr ^ 7'h01, 1'b0});
			`CHK(ack, 1'b0)
		end
		hiPin <= 2'h1;
		loPin <= 2'h1;
		adr = expAddr(2'h1, 2'h1);
		wrB(1'b1, 1'b0, {adr, 1'b0});
		wrB(1'b0, 1'b0, 8'hAA);
		wrB(1'b0, 1'b1, 8'h0F);
		flip(8'hF0);
		`CHK(alertOe, 1'b0)
		flip(8'h80);
		wrB(1'b1, 1'b0, {adr, 1'b1});
		rdB(1'b0);
		`CHK(rx, sense)
		rdB(1'b1);
		`CHK(rx, 8'hF0)
		flip(8'h01);
		`CHK(alertOe, 1'b1)
		old = sense;
		wrB(1'b1, 1'b0, {adr, 1'b1});
		`CHK(alertOe, 1'b0)
		flip(8'h02);
		`CHK(alertOe, 1'b0)
		rdB(1'b1);
		`CHK(rx, old)
		repeat (20) @(posedge mclk);
		`CHK(alertOe, 1'b1)
		wrB(1'b1, 1'b0, {adr, 1'b1});
		rdB(1'b0);
		`CHK(rx, sense)
		flip(8'h04);
		rdB(1'b0);
		`CHK(rx, 8'h02)
		rdB(1'b0);
		`CHK(rx, sense)
		rdB(1'b1);
		`CHK(rx, 8'h04)
		repeat (20) @(posedge mclk);
		`CHK(alertOe, 1'b0)
		for (int k = 0; k < 6; k++) begin
			rx2 = $random(seed);
			flip(rx2 ^ sense);
			wrB(1'b1, 1'b0, {adr, 1'b1});
			rdB(1'b1);
			`CHK(rx, rx2)
		end
		wrB(1'b1, 1'b0, {adr, 1'b0});
		flip(8'h08);
		`CHK(alertOe, 1'b1)
		@(posedge mclk);
		abort_b <= 1'b0;
		repeat (10) @(posedge mclk);
		abort_b <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK(alertOe, 1'b1)
		wrB(1'b0, 1'b1, 8'h00);
		`CHK(ack, 1'b0)
		wrB(1'b1, 1'b1, {adr, 1'b0});
		flip(8'h08);
		`CHK(alertOe, 1'b1)
		tally_and_finish;
	end
endmodule
